// >>> tb/pecc_host.sv
// Host bus controller model issuing register frames
`timescale 1ns/1ps
module pecc_host
  import pecc_pkg::*;
(
  // Bus pins
  output logic csN,
  output logic ck,
  output logic [7:0] dqIn,
  output wire logic rwdsIn,
  input pecc_link_out_t linkOut
);
  assign rwdsIn = linkOut.rwdsOe & linkOut.rwdsOut;
  initial begin
    csN = 1'h1;
    ck = 1'h0;
    dqIn = 8'h00;
  end
  // Eighteen edges per frame so the clock parks low again
  task xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [7:0] b [0:7];
    b = '{cmd, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03, wd[15:8], wd[7:0]};
    csN = 1'h0;
    #16;
    for (int i = 0; i < 18; i++) begin
      // Released lines show the device drive or toggle, never a stale byte
      dqIn = (i < 6 || (i < 8 && cmd == 8'h60)) ? b[i] : (linkOut.dqOe ? linkOut.dqOut : ~dqIn);
      #8;
      if (i == 15) rd[15:8] = linkOut.dqOut;
      if (i == 16) rd[7:0] = linkOut.dqOut;
      ck = ~ck;
      #8;
    end
    csN = 1'h1;
    #16;
  endtask : xfer
endmodule : pecc_host

// >>> tb/pecc_monitor.sv
// Port checker for the ECC register and event flag block
`timescale 1ns/1ps
module pecc_monitor
  import pecc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus and array ports
  input wire logic csN,
  input pecc_link_out_t linkOut,
  input wire logic errOut,
  input wire logic [3:0] wrNib,
  input wire logic wrValid,
  input pecc_code_t wrCode,
  input pecc_code_t rdCode,
  input pecc_nib_t rdNib
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Saturating idle count, so a late flag drop after a frame is still allowed
  logic [3:0] hiCnt_r;
  always_ff @(posedge mclk) begin
    hiCnt_r <= (!rst_n || !csN) ? 4'h0 : hiCnt_r + {3'h0, hiCnt_r != 4'hF};
  end
  a_reset_err_low: assert property ($rose(rst_n) |-> !errOut && !linkOut.dqOe)
    else $error("event or drive active after reset");
  a_err_sticky: assert property ($fell(errOut) |-> hiCnt_r < 4'hC)
    else $error("event output dropped outside a register write");
  a_err_cause: assert property ($rose(errOut) |-> $past(rdCode.valid))
    else $error("event output rose without a read");
  a_dec_latency: assert property (rdCode.valid |=> rdNib.valid)
    else $error("decoded nibble late");
  a_enc_latency: assert property (wrValid |=> wrCode.valid)
    else $error("encoded word late");
  a_enc_zero: assert property (wrValid && wrNib == 4'h0 |=> wrCode.code == 8'h00)
    else $error("zero nibble encoded wrongly");
  a_dec_clean: assert property (rdCode.valid && rdCode.code == 8'hFF |=> rdNib.nib == 4'hF)
    else $error("clean word decoded wrongly");
  a_idle_no_drive: assert property (csN && $past(csN, 4) |-> !linkOut.dqOe && !linkOut.rwdsOe)
    else $error("pins driven while deselected");
  a_beat_strobe: assert property ($rose(linkOut.rwdsOut) |-> linkOut.rwdsOe && linkOut.dqOe)
    else $error("first read beat strobe without data drive");
endmodule : pecc_monitor

bind pecc_top pecc_monitor mon (.mclk(mclk), .rst_n(rst_n), .csN(csN), .linkOut(linkOut), .errOut(errOut),
  .wrNib(wrNib), .wrValid(wrValid), .wrCode(wrCode), .rdCode(rdCode), .rdNib(rdNib));

// >>> tb/pecc_tb_top.sv
// Self-checking bench for the ECC register and event flag block
`timescale 1ns/1ps
module pecc_tb_top;
  import pecc_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] wrNib = 4'h0;
  logic wrValid = 1'h0;
  pecc_code_t rdCode = '0;
  logic csN, ck, rwdsIn, errOut;
  logic [7:0] dqIn;
  logic [15:0] rv;
  logic [3:0] nb;
  pecc_link_out_t linkOut;
  pecc_code_t wrCode;
  pecc_nib_t rdNib;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  pecc_top dut (.mclk(mclk), .rst_n(rst_n), .csN(csN), .ck(ck), .dqIn(dqIn), .rwdsIn(rwdsIn),
    .linkOut(linkOut), .errOut(errOut), .wrNib(wrNib), .wrValid(wrValid), .wrCode(wrCode),
    .rdCode(rdCode), .rdNib(rdNib));
  pecc_host host (.csN(csN), .ck(ck), .dqIn(dqIn), .rwdsIn(rwdsIn), .linkOut(linkOut));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Parity bit k covers every position whose one-based index has bit k set
  function automatic logic [7:0] enc(input logic [3:0] d);
    logic [7:0] e;
    e = 8'h00;
    e[2] = d[0];
    e[4] = d[1];
    e[5] = d[2];
    e[6] = d[3];
    for (int k = 0; k < 3; k++) begin
      for (int j = 2; j < 7; j++) begin
        if ((((j + 1) >> k) & 1) == 1) e[(1 << k) - 1] = e[(1 << k) - 1] ^ e[j];
      end
    end
    e[7] = ^e[6:0];
    return e;
  endfunction : enc
  task rdr(input logic [7:0] cmd, input logic [15:0] e);
    @(posedge mclk);
    #1;
    host.xfer(cmd, 16'h0000, rv);
    chk("register", e, rv);
  endtask : rdr
  task wrr(input logic [7:0] cmd, input logic [15:0] w);
    @(posedge mclk);
    #1;
    host.xfer(cmd, w, rv);
  endtask : wrr
  task inj(input logic [7:0] c, input logic ex);
    @(posedge mclk);
    #1;
    rdCode = {1'h1, c};
    @(posedge mclk);
    #1;
    rdCode.valid = 1'h0;
    nb = rdNib.nib;
    @(posedge mclk);
    #1;
    chk("event output", {15'h0, ex}, {15'h0, errOut});
  endtask : inj
  task t_reset();
    rdr(8'hC0, 16'hE000);
    rdr(8'hE0, 16'hE000);
    chk("event output", 16'h0000, {15'h0, errOut});
  endtask : t_reset
  task t_codec();
    for (int n = 0; n < 16; n++) begin
      @(posedge mclk);
      #1;
      wrNib = n[3:0];
      wrValid = 1'h1;
      @(posedge mclk);
      #1;
      wrValid = 1'h0;
      chk("code word", {8'h00, enc(n[3:0])}, {8'h00, wrCode.code});
      for (int k = 0; k < 8; k++) begin
        inj(enc(n[3:0]) ^ (8'h01 << k), 1'h1);
        chk("fixed nibble", n[15:0], {12'h0, nb});
      end
    end
    rdr(8'hC0, 16'hE800);
    inj(enc(4'h5) ^ 8'h03, 1'h1);
    rdr(8'hC0, 16'hEC00);
  endtask : t_codec
  task t_types();
    for (int t = 0; t < 4; t++) begin
      wrr(8'h60, 16'hC200 | (t[15:0] << 12));
      inj(enc(4'hA) ^ 8'h10, t == 0 || t == 2);
      wrr(8'h60, 16'hC200 | (t[15:0] << 12));
      inj(enc(4'hA) ^ 8'h30, t == 1 || t == 2);
      rdr(8'hC0, 16'hC400 | (t[15:0] << 12));
    end
  endtask : t_types
  task t_off_refuse();
    wrr(8'h60, 16'h6200);
    inj(enc(4'h3) ^ 8'h04, 1'h0);
    wrr(8'h60, 16'h8000);
    inj(enc(4'h3) ^ 8'h04, 1'h0);
    wrr(8'h20, 16'hE000);
    rdr(8'hC0, 16'h8800);
  endtask : t_off_refuse
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'h1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_codec();
    t_types();
    t_off_refuse();
    report_and_stop();
  end
endmodule : pecc_tb_top

// >>> verilog/pecc_defs.svh
// Constants for the memory ECC configuration and error flag block
`ifndef PECC_DEFS_SVH
`define PECC_DEFS_SVH
`define PECC_BIT_EN 15
`define PECC_BIT_OUTEN 14
`define PECC_BIT_TYPE_HI 13
`define PECC_BIT_TYPE_LO 12
`define PECC_BIT_HIST1 11
`define PECC_BIT_HIST2 10
`define PECC_BIT_CLR 9
`define PECC_RST_EN 1'h1
`define PECC_RST_OUTEN 1'h1
`define PECC_RST_TYPE 2'h2
`define PECC_TYPE_SINGLE 2'h0
`define PECC_TYPE_DOUBLE 2'h1
`define PECC_TYPE_ANY 2'h2
`define PECC_CMD_RD_A 8'hC0
`define PECC_CMD_RD_B 8'hE0
`define PECC_CMD_WR 8'h60
`define PECC_CA_TAIL 40'h0001000003
`define PECC_CA_BYTES 3'h6
`define PECC_LAT_CLOCKS 4
`define PECC_LAT_EDGES 4'h8
`endif

// >>> verilog/pecc_pkg.sv
// Types for the memory ECC configuration and error flag block
package pecc_pkg;
  typedef enum logic [2:0] {
    PECC_IDLE = 3'h0,
    PECC_CMD = 3'h1,
    PECC_RLAT = 3'h3,
    PECC_RDATA = 3'h2,
    PECC_WDATA = 3'h5,
    PECC_DONE = 3'h4
  } pecc_state_t;

  typedef struct packed {
    logic [7:0] dqOut;
    logic dqOe;
    logic rwdsOut;
    logic rwdsOe;
  } pecc_link_out_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } pecc_code_t;

  typedef struct packed {
    logic valid;
    logic [3:0] nib;
  } pecc_nib_t;

  typedef struct packed {
    logic [1:0] ckSync;
    logic [1:0] csSync;
    logic [15:0] dqSync;
    logic ckPrev;
    pecc_state_t state;
    logic [2:0] byteCnt;
    logic [3:0] latCnt;
    logic [47:0] caShift;
    logic isWrite;
    logic [7:0] wrHigh;
    logic corrEn;
    logic outEn;
    logic [1:0] indType;
    logic hist1;
    logic hist2;
    logic clrBit;
    logic err;
    pecc_link_out_t link;
    pecc_code_t wrCode;
    pecc_nib_t rdNib;
  } pecc_state_s_t;
endpackage : pecc_pkg

// >>> verilog/pecc_top.sv
// ECC configuration/status register, error flag and nibble SECDED codec
//
// Notes on behaviour
// - Each 4-bit chunk is stored as 8 bits; single errors fixed, doubles flagged.
// - Register access: C0/E0 or 60, then 00,01,00,00,03; writes send high byte first.
// - Register reads and writes use configuration register latency and transfer timing.
// - Bit 15 enables correction; resets to one.
// - Bit 14 enables event output, resets to one, effective only with correction on.
// - Bits 13-12 pick events: 00 single, 01 double, 10 any; 11 reserved.
// - Bit 11 reads one once a single-bit correction has happened.
// - Bit 10 reads one once a double-bit detection has happened.
// - Writing one to bit 9 clears both histories and event output, then self-clears.
// - Bits 8 to 0 are reserved and read zero.
// - Event output stays high until cleared by bit 9, reset, or a write of zero to bit 15 or bit 14.
// - Event output rises no later than the first data beat of the affected read.
// - After reset with both enables set, event output is driven low.
// - Event output is not aligned to the bus clock edges.
// - Event output never asserts while correction is disabled.
// - Select falling starts a transaction, rising ends it.
`timescale 1ns/1ps
`include "pecc_defs.svh"

module pecc_top
  import pecc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Memory bus pins
  input wire logic csN,
  input wire logic ck,
  input wire logic [7:0] dqIn,
  input wire logic rwdsIn,
  output pecc_link_out_t linkOut,
  output logic errOut,
  // Array side: nibble to store, code word read back
  input wire logic [3:0] wrNib,
  input wire logic wrValid,
  output pecc_code_t wrCode,
  input pecc_code_t rdCode,
  output pecc_nib_t rdNib
);

  pecc_state_s_t s_r;
  pecc_state_s_t s_nxt;

  function automatic logic [7:0] encode(input logic [3:0] d);
    logic [6:0] c;
    c = {d[3], d[2], d[1], d[1] ^ d[2] ^ d[3], d[0], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
    encode = {^c, c};
  endfunction : encode

  function automatic logic [15:0] regImage(input pecc_state_s_t s);
    regImage = {s.corrEn, s.outEn, s.indType, s.hist1, s.hist2, s.clrBit, 9'h000};
  endfunction : regImage

  logic [2:0] syn;
  logic parOdd;
  logic [7:0] fixed;
  logic evSingle;
  logic evDouble;
  logic trigger;
  logic ckEdge;
  logic [7:0] dqNow;
  logic [47:0] caNext;
  logic cmdOk;
  logic [15:0] wrWord;
  logic [15:0] regNow;

  // Decoder for the code word coming back from the array
  always_comb begin
    syn = {rdCode.code[3] ^ rdCode.code[4] ^ rdCode.code[5] ^ rdCode.code[6],
           rdCode.code[1] ^ rdCode.code[2] ^ rdCode.code[5] ^ rdCode.code[6],
           rdCode.code[0] ^ rdCode.code[2] ^ rdCode.code[4] ^ rdCode.code[6]};
    parOdd = ^rdCode.code;
    fixed = rdCode.code;
    if (syn != 3'h0 && parOdd) begin
      fixed[syn - 3'h1] = ~rdCode.code[syn - 3'h1];
    end
    evSingle = rdCode.valid && s_r.corrEn && parOdd;
    evDouble = rdCode.valid && s_r.corrEn && !parOdd && syn != 3'h0;
    case (s_r.indType)
      `PECC_TYPE_SINGLE: trigger = evSingle;
      `PECC_TYPE_DOUBLE: trigger = evDouble;
      `PECC_TYPE_ANY: trigger = evSingle || evDouble;
      default: trigger = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    ckEdge = s_r.ckSync[1] != s_r.ckPrev;
    dqNow = s_r.dqSync[15:8];
    caNext = {s_r.caShift[39:0], dqNow};
    cmdOk = (caNext[47:40] == `PECC_CMD_RD_A || caNext[47:40] == `PECC_CMD_RD_B
             || caNext[47:40] == `PECC_CMD_WR) && caNext[39:0] == `PECC_CA_TAIL;
    wrWord = {s_r.wrHigh, dqNow};
    // Function results cannot be sliced directly, so the image is held in a variable
    regNow = regImage(s_r);

    // Pins pass two flops before use
    s_nxt.ckSync = {s_r.ckSync[0], ck};
    s_nxt.csSync = {s_r.csSync[0], csN};
    s_nxt.dqSync = {s_r.dqSync[7:0], dqIn};
    s_nxt.ckPrev = s_r.ckSync[1];
    s_nxt.clrBit = 1'b0;

    // Array codec path, bypassed when correction is off
    s_nxt.wrCode.valid = wrValid;
    s_nxt.wrCode.code = s_r.corrEn ? encode(wrNib) : {4'h0, wrNib};
    s_nxt.rdNib.valid = rdCode.valid;
    s_nxt.rdNib.nib = s_r.corrEn ? {fixed[6], fixed[5], fixed[4], fixed[2]}
                                 : {rdCode.code[6], rdCode.code[5], rdCode.code[4], rdCode.code[2]};

    case (s_r.state)
      PECC_IDLE: begin
        s_nxt.link = '0;
        if (!s_r.csSync[1] && !s_r.ckSync[1]) begin
          s_nxt.state = PECC_CMD;
          s_nxt.byteCnt = 3'h0;
          s_nxt.link.rwdsOe = 1'b1;
          s_nxt.link.rwdsOut = 1'b0;
        end
      end
      PECC_CMD: begin
        if (ckEdge) begin
          s_nxt.caShift = caNext;
          s_nxt.byteCnt = s_r.byteCnt + 3'h1;
          if (s_r.byteCnt + 3'h1 == `PECC_CA_BYTES) begin
            s_nxt.link.rwdsOe = 1'b0;
            s_nxt.latCnt = 4'h0;
            s_nxt.byteCnt = 3'h0;
            s_nxt.isWrite = caNext[47:40] == `PECC_CMD_WR;
            if (!cmdOk) begin
              s_nxt.state = PECC_DONE;
            end else if (caNext[47:40] == `PECC_CMD_WR) begin
              s_nxt.state = PECC_WDATA;
            end else begin
              s_nxt.state = PECC_RLAT;
            end
          end
        end
      end
      PECC_RLAT: begin
        if (ckEdge) begin
          s_nxt.latCnt = s_r.latCnt + 4'h1;
          if (s_r.latCnt + 4'h1 == `PECC_LAT_EDGES) begin
            s_nxt.state = PECC_RDATA;
            s_nxt.link.dqOe = 1'b1;
            s_nxt.link.rwdsOe = 1'b1;
            s_nxt.link.rwdsOut = 1'b0;
          end
        end
      end
      PECC_RDATA: begin
        if (ckEdge) begin
          s_nxt.byteCnt = s_r.byteCnt + 3'h1;
          s_nxt.link.rwdsOut = !s_r.byteCnt[0];
          s_nxt.link.dqOut = s_r.byteCnt[0] ? regNow[7:0] : regNow[15:8];
          if (s_r.byteCnt == 3'h2) begin
            s_nxt.link = '0;
            s_nxt.state = PECC_DONE;
          end
        end
      end
      PECC_WDATA: begin
        if (ckEdge) begin
          s_nxt.byteCnt = s_r.byteCnt + 3'h1;
          if (s_r.byteCnt == 3'h0) begin
            s_nxt.wrHigh = dqNow;
          end else begin
            s_nxt.corrEn = wrWord[`PECC_BIT_EN];
            s_nxt.outEn = wrWord[`PECC_BIT_OUTEN];
            s_nxt.indType = wrWord[`PECC_BIT_TYPE_HI:`PECC_BIT_TYPE_LO];
            s_nxt.clrBit = wrWord[`PECC_BIT_CLR];
            s_nxt.state = PECC_DONE;
          end
        end
      end
      PECC_DONE: begin
        s_nxt.link = '0;
      end
      default: begin
        s_nxt.state = PECC_IDLE;
      end
    endcase

    // A rising select ends any transaction at once
    if (s_r.csSync[1]) begin
      s_nxt.state = PECC_IDLE;
      s_nxt.link = '0;
    end

    // Set wins over a clear landing in the same cycle
    s_nxt.hist1 = evSingle || (s_r.hist1 && !s_r.clrBit);
    s_nxt.hist2 = evDouble || (s_r.hist2 && !s_r.clrBit);
    // Event flag follows the array, not the link clock, so it leads the first beat
    s_nxt.err = (trigger || (s_r.err && !s_r.clrBit))
                && s_nxt.corrEn && s_nxt.outEn;

    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.ckSync = 2'h0;
      s_nxt.csSync = 2'h3;
      s_nxt.state = PECC_IDLE;
      s_nxt.corrEn = `PECC_RST_EN;
      s_nxt.outEn = `PECC_RST_OUTEN;
      s_nxt.indType = `PECC_RST_TYPE;
      s_nxt.err = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign linkOut = s_r.link;
  assign errOut = s_r.err;
  assign wrCode = s_r.wrCode;
  assign rdNib = s_r.rdNib;

endmodule : pecc_top
